// [design/nfh_consts.vh]
`ifndef NFH_CONSTS_VH
`define NFH_CONSTS_VH
// ************************************************************
// Clock and timing figures for the flash host.
// ************************************************************
`define NFH_CLK_PERIOD_NS 100
// Full address or select access delay, in ns.
`define NFH_FULL_ACCESS_NS 90
// In-page access delay, in ns.
`define NFH_PAGE_ACCESS_NS 25
// Write-enable low width and high width, in ns.
`define NFH_WE_LOW_NS 100
`define NFH_WE_HIGH_NS 100
// Hardware reset pulse width and recovery before the first access, in ns.
`define NFH_RST_PULSE_NS 500
`define NFH_RST_RECOVER_NS 200
// Least delays round up to whole cycles, never below one.
`define NFH_CEIL_CYC(ns) ((((ns) + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS))
`define NFH_FULL_ACCESS_CYC `NFH_CEIL_CYC(`NFH_FULL_ACCESS_NS)
`define NFH_PAGE_ACCESS_CYC `NFH_CEIL_CYC(`NFH_PAGE_ACCESS_NS)
`define NFH_WE_LOW_CYC `NFH_CEIL_CYC(`NFH_WE_LOW_NS)
`define NFH_WE_HIGH_CYC `NFH_CEIL_CYC(`NFH_WE_HIGH_NS)
`define NFH_RST_PULSE_CYC `NFH_CEIL_CYC(`NFH_RST_PULSE_NS)
`define NFH_RST_RECOVER_CYC `NFH_CEIL_CYC(`NFH_RST_RECOVER_NS)
// Two synchroniser stages sit between the data pins and the capture.
`define NFH_SYNC_CYC 2
// ************************************************************
// Command codes on the user port.
// ************************************************************
`define NFH_OP_READ 2'h0
`define NFH_OP_WRITE 2'h1
`define NFH_OP_RESET 2'h2
// ************************************************************
// Field widths and positions.
// ************************************************************
`define NFH_TIMER_W 8
`define NFH_LSB_BYTE_ADDRESS_BIT 15
`define NFH_ADDR_MSB 21
`endif

// [design/nfh_timer.v]
`timescale 1ns/1ps
`default_nettype none
`include "nfh_consts.vh"
// ************************************************************
// Down counter that times each phase of a flash cycle.
// ************************************************************
module nfh_timer (
  input wire clk,
  input wire arst_n,
  input wire load,
  input wire [`NFH_TIMER_W-1:0] load_val,
  output wire done
);
  // Power-up load value; the 32-bit form is cut to the counter width on purpose.
  localparam [31:0] RST_INIT_W32 = `NFH_RST_PULSE_CYC;

  reg [`NFH_TIMER_W-1:0] count_reg;

  // The counter starts loaded with the reset pulse width, so the flash reset begins at power-up.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= RST_INIT_W32[`NFH_TIMER_W-1:0];
    end else if (load) begin
      count_reg <= load_val;
    end else if (count_reg != {`NFH_TIMER_W{1'b0}}) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // Done depends on the count alone, so a caller may load from done without a loop.
  assign done = (count_reg == {`NFH_TIMER_W{1'b0}}); // Done once the phase has elapsed.
endmodule // nfh_timer
`default_nettype wire

// [design/nfh_host.v]
`timescale 1ns/1ps
`default_nettype none
`include "nfh_consts.vh"
module nfh_host (
  input wire clk,
  input wire arst_n,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [1:0] cmd_op,
  input wire [22:0] cmd_addr,
  input wire [15:0] cmd_wdata,
  output reg rsp_valid_reg,
  output reg [15:0] rsp_rdata_reg,
  input wire byte_mode,
  input wire standby_req,
  input wire accel_req,
  input wire protect_level,
  output reg flash_ce_n_reg,
  output reg flash_oe_n_reg,
  output reg flash_we_n_reg,
  output reg flash_reset_n_reg,
  output reg flash_byte_n_reg,
  output reg [21:0] flash_addr_reg,
  input wire [15:0] flash_dq_in,
  output reg [15:0] flash_dq_out_reg,
  output reg [15:0] flash_dq_oe_reg,
  output reg protect_drive_reg,
  output reg high_voltage_en_reg
);
  // ************************************************************
  // States of the cycle sequencer.
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD_WAIT = 3'h1;
  localparam [2:0] ST_WR_SETUP = 3'h2;
  localparam [2:0] ST_WR_LOW = 3'h3;
  localparam [2:0] ST_WR_HIGH = 3'h4;
  localparam [2:0] ST_RST_LOW = 3'h5;
  localparam [2:0] ST_RST_RECOVER = 3'h6;

  // Phase lengths in cycles; the 32-bit forms are cut to the timer width on purpose.
  localparam [31:0] FULL_RD_W32 = `NFH_FULL_ACCESS_CYC + `NFH_SYNC_CYC;
  localparam [31:0] PAGE_RD_W32 = `NFH_PAGE_ACCESS_CYC + `NFH_SYNC_CYC;
  localparam [31:0] WE_LOW_W32 = `NFH_WE_LOW_CYC;
  localparam [31:0] WE_HIGH_W32 = `NFH_WE_HIGH_CYC;
  localparam [31:0] RST_LOW_W32 = `NFH_RST_PULSE_CYC;
  localparam [31:0] RST_RECOVER_W32 = `NFH_RST_RECOVER_CYC;
  localparam [`NFH_TIMER_W-1:0] FULL_RD_CYC = FULL_RD_W32[`NFH_TIMER_W-1:0];
  localparam [`NFH_TIMER_W-1:0] PAGE_RD_CYC = PAGE_RD_W32[`NFH_TIMER_W-1:0];
  localparam [`NFH_TIMER_W-1:0] WE_LOW_CYC = WE_LOW_W32[`NFH_TIMER_W-1:0];
  localparam [`NFH_TIMER_W-1:0] WE_HIGH_CYC = WE_HIGH_W32[`NFH_TIMER_W-1:0];
  localparam [`NFH_TIMER_W-1:0] RST_LOW_CYC = RST_LOW_W32[`NFH_TIMER_W-1:0];
  localparam [`NFH_TIMER_W-1:0] RST_RECOVER_CYC = RST_RECOVER_W32[`NFH_TIMER_W-1:0];

  reg [2:0] state_reg;
  reg page_valid_reg;
  reg [19:0] page_tag_reg;
  reg [15:0] dq_meta_reg;
  reg [15:0] dq_sync_reg;
  reg timer_load;
  reg [`NFH_TIMER_W-1:0] timer_val;
  wire timer_done;
  wire is_read;
  wire take;
  wire same_page;

  // ************************************************************
  // Address helpers.
  // ************************************************************

  // Page number: word address bits 21..2, or byte address bits 22..3.
  function [19:0] page_of;
    input [22:0] addr;
    input byte_sel;
    begin
      page_of = byte_sel ? addr[22:3] : addr[21:2];
    end
  endfunction

  // Pin address: in byte mode the lowest byte address bit leaves for line fifteen.
  function [21:0] pin_addr_of;
    input [22:0] addr;
    input byte_sel;
    begin
      pin_addr_of = byte_sel ? addr[22:1] : addr[21:0];
    end
  endfunction

  // ************************************************************
  // Request acceptance.
  // ************************************************************

  // Reads are held off while high voltage is requested, so it only meets program cycles.
  assign is_read = (cmd_op == `NFH_OP_READ);
  assign cmd_ready = (state_reg == ST_IDLE) && !(is_read && accel_req);
  assign take = cmd_valid && cmd_ready;
  // A same-page hit needs select still low, unchanged width and an unchanged page.
  assign same_page = page_valid_reg && !flash_ce_n_reg &&
    (flash_byte_n_reg == !byte_mode) &&
    (page_tag_reg == page_of(cmd_addr, byte_mode));

  // Data pins are outside the clock domain and pass two flip-flops before use.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_meta_reg <= 16'h0000;
      dq_sync_reg <= 16'h0000;
    end else begin
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // Phase timer shared by reads, writes and the reset pulse.
  nfh_timer u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .load(timer_load),
    .load_val(timer_val),
    .done(timer_done)
  );

  // Selects which delay the next phase waits for.
  always @* begin
    timer_load = 1'b0;
    timer_val = {`NFH_TIMER_W{1'b0}};
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          timer_load = 1'b1;
          case (cmd_op)
            `NFH_OP_READ: timer_val = same_page ? PAGE_RD_CYC : FULL_RD_CYC;
            `NFH_OP_RESET: timer_val = RST_LOW_CYC;
            default: timer_val = {`NFH_TIMER_W{1'b0}};
          endcase
        end
      end
      ST_WR_SETUP: begin
        timer_load = 1'b1;
        timer_val = WE_LOW_CYC;
      end
      ST_WR_LOW: begin
        timer_load = timer_done;
        timer_val = WE_HIGH_CYC;
      end
      ST_RST_LOW: begin
        timer_load = timer_done;
        timer_val = RST_RECOVER_CYC;
      end
      default: begin
        timer_load = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Cycle sequencer and pin drivers.
  // ************************************************************

  // The flash is held in reset while the host is; a reset pulse then runs at release.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_RST_LOW;
      page_valid_reg <= 1'b0;
      page_tag_reg <= 20'h00000;
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 16'h0000;
      flash_ce_n_reg <= 1'b1;
      flash_oe_n_reg <= 1'b1;
      flash_we_n_reg <= 1'b1;
      flash_reset_n_reg <= 1'b0;
      flash_byte_n_reg <= 1'b1;
      flash_addr_reg <= 22'h000000;
      flash_dq_out_reg <= 16'h0000;
      flash_dq_oe_reg <= 16'h0000;
      protect_drive_reg <= 1'b0;
      high_voltage_en_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      protect_drive_reg <= protect_level;
      case (state_reg)
        ST_IDLE: begin
          // Standby deselects; otherwise select stays low after a read for page hits.
          flash_oe_n_reg <= 1'b1;
          flash_we_n_reg <= 1'b1;
          flash_dq_oe_reg <= 16'h0000;
          high_voltage_en_reg <= accel_req;
          if (standby_req || !page_valid_reg) begin
            flash_ce_n_reg <= 1'b1;
            page_valid_reg <= 1'b0;
          end
          if (take) begin
            flash_byte_n_reg <= !byte_mode;
            flash_addr_reg <= pin_addr_of(cmd_addr, byte_mode);
            flash_dq_out_reg <= cmd_wdata;
            if (byte_mode) begin
              flash_dq_out_reg[`NFH_LSB_BYTE_ADDRESS_BIT] <= cmd_addr[0];
            end
            case (cmd_op)
              `NFH_OP_READ: begin
                flash_ce_n_reg <= 1'b0;
                flash_oe_n_reg <= 1'b0;
                flash_dq_oe_reg <= {byte_mode, 15'h0000};
                page_valid_reg <= 1'b1;
                page_tag_reg <= page_of(cmd_addr, byte_mode);
                state_reg <= ST_RD_WAIT;
              end
              `NFH_OP_WRITE: begin
                flash_ce_n_reg <= 1'b1;
                page_valid_reg <= 1'b0;
                state_reg <= ST_WR_SETUP;
              end
              `NFH_OP_RESET: begin
                flash_ce_n_reg <= 1'b1;
                flash_reset_n_reg <= 1'b0;
                page_valid_reg <= 1'b0;
                high_voltage_en_reg <= 1'b0;
                state_reg <= ST_RST_LOW;
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        ST_RD_WAIT: begin
          // Capture once access time plus synchroniser delay has elapsed.
          if (timer_done) begin
            rsp_rdata_reg <= !flash_byte_n_reg ? {8'h00, dq_sync_reg[7:0]} : dq_sync_reg;
            rsp_valid_reg <= 1'b1;
            flash_oe_n_reg <= 1'b1;
            flash_dq_oe_reg <= 16'h0000;
            state_reg <= ST_IDLE;
          end
        end
        ST_WR_SETUP: begin
          // Address and data settle with output enable high before write enable falls.
          flash_ce_n_reg <= 1'b0;
          flash_oe_n_reg <= 1'b1;
          flash_dq_oe_reg <= flash_byte_n_reg ? 16'hFFFF : 16'h80FF;
          state_reg <= ST_WR_LOW;
        end
        ST_WR_LOW: begin
          flash_we_n_reg <= timer_done;
          if (timer_done) begin
            state_reg <= ST_WR_HIGH;
          end
        end
        ST_WR_HIGH: begin
          // Data is held through the high phase, then the device is released.
          if (timer_done) begin
            flash_ce_n_reg <= 1'b1;
            flash_dq_oe_reg <= 16'h0000;
            state_reg <= ST_IDLE;
          end
        end
        ST_RST_LOW: begin
          if (timer_done) begin
            flash_reset_n_reg <= 1'b1;
            state_reg <= ST_RST_RECOVER;
          end
        end
        ST_RST_RECOVER: begin
          if (timer_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // nfh_host
`default_nettype wire

// [sim/nfh_host_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Pin protocol checks for the flash host.
// ****
module nfh_host_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic rsp_valid_reg,
  input wire logic flash_ce_n_reg,
  input wire logic flash_oe_n_reg,
  input wire logic flash_we_n_reg,
  input wire logic flash_reset_n_reg,
  input wire logic flash_byte_n_reg,
  input wire logic [15:0] flash_dq_oe_reg,
  input wire logic high_voltage_en_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Accepted requests and the pin steps that must follow them.
  sequence take_read; cmd_valid && cmd_ready && cmd_op == 2'h0; endsequence
  sequence take_write; cmd_valid && cmd_ready && cmd_op == 2'h1; endsequence
  sequence read_strobe;
    ##[0:1] (!flash_oe_n_reg && !flash_ce_n_reg) [*3] ##[1:2] rsp_valid_reg;
  endsequence
  sequence write_strobe;
    flash_we_n_reg [*2] ##[1:2] !flash_we_n_reg ##1 flash_we_n_reg;
  endsequence
  a_read_levels: assert property (
    !flash_oe_n_reg |-> !flash_ce_n_reg && flash_we_n_reg && flash_reset_n_reg)
    else $error("Bad read levels.");
  a_write_levels: assert property (
    !flash_we_n_reg |-> !flash_ce_n_reg && flash_oe_n_reg && flash_dq_oe_reg[7:0] == 8'hFF)
    else $error("Bad write levels.");
  a_no_overlap: assert property (flash_oe_n_reg || flash_we_n_reg)
    else $error("Both strobes low.");
  a_read_float: assert property (
    !flash_oe_n_reg |-> flash_dq_oe_reg == (flash_byte_n_reg ? 16'h0000 : 16'h8000))
    else $error("Host drives data during a read.");
  a_read_seq: assert property (take_read |=> read_strobe)
    else $error("Read cycle timing wrong.");
  a_write_seq: assert property (take_write |=> write_strobe)
    else $error("Write cycle timing wrong.");
  a_rsp_pulse: assert property (rsp_valid_reg |=> !rsp_valid_reg)
    else $error("Response longer than one cycle.");
  a_hv_no_read: assert property (high_voltage_en_reg |-> flash_oe_n_reg)
    else $error("Read under high voltage.");
  a_reset_pulse: assert property (
    $fell(flash_reset_n_reg) |-> !flash_reset_n_reg [*6] ##1 flash_reset_n_reg)
    else $error("Pin reset pulse width wrong.");
endmodule // nfh_host_monitor
bind nfh_host nfh_host_monitor mon_u (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rsp_valid_reg(rsp_valid_reg),
  .flash_ce_n_reg(flash_ce_n_reg), .flash_oe_n_reg(flash_oe_n_reg),
  .flash_we_n_reg(flash_we_n_reg), .flash_reset_n_reg(flash_reset_n_reg),
  .flash_byte_n_reg(flash_byte_n_reg), .flash_dq_oe_reg(flash_dq_oe_reg),
  .high_voltage_en_reg(high_voltage_en_reg));
`default_nettype wire

// [sim/nfh_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Behavioural flash part seen from its pins.
// ****
module nfh_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h3C // Arbitrary value.
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic byte_n,
  input wire logic [21:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] dev_out,
  output logic [15:0] dev_oe
);
  logic ident_mode = 1'b0;
  logic data_ok = 1'b0;
  logic [21:0] last_addr = 22'h000000;
  logic [15:0] word;
  // The command latch is off the address map; a pin reset restores array reads.
  always @(posedge we_n or negedge reset_n) begin
    if (!reset_n) ident_mode <= 1'b0;
    else if (!ce_n && dq[7:0] == 8'h90) ident_mode <= 1'b1;
    else if (!ce_n && dq[7:0] == 8'hF0) ident_mode <= 1'b0;
  end
  // Full delay after select or a new page, short delay inside an open page.
  always @(addr or ce_n) begin
    data_ok = 1'b0;
    data_ok <= #((!ce_n && last_addr[21:2] == addr[21:2]) ? 25 : 90) 1'b1;
    last_addr = ce_n ? ~addr : addr;
  end
  // Data shows only when selected and read-enabled; early data is garbage.
  always @* begin
    word = {addr[7:0] ^ 8'hA5, addr[7:0]};
    dev_out = byte_n ? word : {8'h00, dq[15] ? word[15:8] : word[7:0]};
    if (ident_mode) dev_out = {8'h00, ID_CODE};
    if (!data_ok) dev_out = ~dev_out;
    dev_oe = (ce_n || oe_n || !we_n || !reset_n) ? 16'h0000 : (byte_n ? 16'hFFFF : 16'h00FF);
  end
endmodule // nfh_flash_model
`default_nettype wire

// [sim/nfh_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Host block against the behavioural flash part.
// ****
module tb;
  localparam logic [7:0] ID_CODE = 8'h3C; // Arbitrary value.
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [22:0] cmd_addr = 23'h000000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic byte_mode = 1'b0;
  logic standby_req = 1'b0;
  logic accel_req = 1'b0;
  logic protect_level = 1'b0;
  logic [15:0] dq_last = 16'h0000;
  wire cmd_ready, rsp_valid, ce_n, oe_n, we_n, rst_n, byte_n, prot_drv, hv_en;
  wire [15:0] rdata, dq_in, h_out, h_oe, d_out, d_oe;
  wire [21:0] addr;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Wire level: host drive, else part drive, else a value that flips each cycle.
  assign dq_in = (h_oe & h_out) | (~h_oe & d_oe & d_out) | (~h_oe & ~d_oe & ~dq_last);
  always #50 clk = ~clk;
  // Undriven history and the run ceiling.
  always @(posedge clk) begin
    dq_last <= dq_in;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      give_verdict;
    end
  end
  nfh_host dut_u (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid_reg(rsp_valid),
    .rsp_rdata_reg(rdata), .byte_mode(byte_mode), .standby_req(standby_req),
    .accel_req(accel_req), .protect_level(protect_level), .flash_ce_n_reg(ce_n),
    .flash_oe_n_reg(oe_n), .flash_we_n_reg(we_n), .flash_reset_n_reg(rst_n),
    .flash_byte_n_reg(byte_n), .flash_addr_reg(addr), .flash_dq_in(dq_in),
    .flash_dq_out_reg(h_out), .flash_dq_oe_reg(h_oe), .protect_drive_reg(prot_drv),
    .high_voltage_en_reg(hv_en));
  nfh_flash_model #(.ID_CODE(ID_CODE)) part_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .reset_n(rst_n), .byte_n(byte_n), .addr(addr), .dq(dq_in), .dev_out(d_out), .dev_oe(d_oe));
  // Array content at a word address.
  function automatic logic [15:0] wexp(input logic [21:0] w);
    wexp = {w[7:0] ^ 8'hA5, w[7:0]};
  endfunction
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Presents one request and holds it until the edge that takes it.
  task automatic issue(input logic [1:0] op, input logic [22:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk) #1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    check16("cmd_ready", 16'h0001, {15'h0, cmd_ready});
    @(posedge clk) #1;
    cmd_valid = 1'b0;
  endtask
  // Reads one location and compares the returned data.
  task automatic rd(input logic [22:0] a, input logic [15:0] exp, input string what);
    int n;
    n = 0;
    issue(2'h0, a, 16'h0000);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    check16("rsp_valid", 16'h0001, {15'h0, rsp_valid});
    check16(what, exp, rdata);
  endtask
  // Array reads after reset, inside one page and at the top word.
  task automatic t_word_reads;
    rd(23'h000005, wexp(22'h5), "word after reset");
    rd(23'h000006, wexp(22'h6), "page hit");
    rd(23'h000004, wexp(22'h4), "page hit low");
    rd(23'h3FFFFF, wexp(22'h3FFFFF), "top word");
  endtask
  // Byte reads pick the half named by the low address bit.
  task automatic t_byte_reads;
    byte_mode = 1'b1;
    rd(23'h000013, 16'h00AC, "odd byte");
    rd(23'h000012, 16'h0009, "even byte");
    byte_mode = 1'b0;
  endtask
  // Identification mode lasts until an F0 write or a pin reset ends it.
  task automatic t_ident;
    issue(2'h1, 23'h000555, 16'h0090);
    rd(23'h000000, {8'h00, ID_CODE}, "ident code");
    issue(2'h3, 23'h000000, 16'h00F0);
    rd(23'h000001, {8'h00, ID_CODE}, "ident kept");
    issue(2'h2, 23'h000000, 16'h0000);
    rd(23'h000002, wexp(22'h2), "array after pin reset");
    issue(2'h1, 23'h000555, 16'h0090);
    issue(2'h1, 23'h000000, 16'h00F0);
    rd(23'h000003, wexp(22'h3), "array after exit");
  endtask
  // Erase and buffer-load sequences are plain write cycles; the part is left deselected.
  task automatic t_sequences;
    issue(2'h1, 23'h000555, 16'h00AA);
    issue(2'h1, 23'h0002AA, 16'h0055);
    issue(2'h1, 23'h000555, 16'h0080);
    issue(2'h1, 23'h000555, 16'h00AA);
    issue(2'h1, 23'h0002AA, 16'h0055);
    issue(2'h1, 23'h010000, 16'h0030);
    issue(2'h1, 23'h000555, 16'h00AA);
    issue(2'h1, 23'h0002AA, 16'h0055);
    issue(2'h1, 23'h010000, 16'h0025);
    issue(2'h1, 23'h010000, 16'h000F);
    for (int i = 0; i < 16; i++) begin
      issue(2'h1, {19'h01000, i[3:0]}, {12'h120, i[3:0]});
    end
    issue(2'h1, 23'h010000, 16'h0029);
    repeat (6) @(posedge clk);
    #1 check16("ce_n after program", 16'h0001, {15'h0, ce_n});
    rd(23'h010001, wexp(22'h010001), "read after sequences");
  endtask
  // A parked host deselects the part; the next read still gets full access time.
  task automatic t_standby;
    standby_req = 1'b1;
    repeat (3) @(posedge clk);
    #1 check16("ce_n in standby", 16'h0001, {15'h0, ce_n});
    standby_req = 1'b0;
    rd(23'h000007, wexp(22'h7), "read after standby");
  endtask
  // High voltage only on request: reads refused, two-cycle program taken.
  task automatic t_accel;
    accel_req = 1'b1;
    protect_level = 1'b1;
    repeat (2) @(posedge clk);
    #1 check16("read ready under accel", 16'h0000, {15'h0, cmd_ready});
    check16("hv request", 16'h0001, {15'h0, hv_en});
    check16("protect drive", 16'h0001, {15'h0, prot_drv});
    issue(2'h1, 23'h000555, 16'h00A0);
    issue(2'h1, 23'h000040, 16'h1234);
    accel_req = 1'b0;
    protect_level = 1'b0;
    repeat (8) @(posedge clk);
    #1 check16("hv released", 16'h0000, {15'h0, hv_en});
    check16("protect low", 16'h0000, {15'h0, prot_drv});
    rd(23'h000008, wexp(22'h8), "read after accel");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    t_word_reads;
    t_byte_reads;
    t_ident;
    t_sequences;
    t_standby;
    t_accel;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
